// ### hw/emc_regs.svh
`ifndef EMC_REGS_SVH
`define EMC_REGS_SVH
`define EMC_OFS_CSR 16'hffeb
`define EMC_OFS_BASE0 16'hffe8
`define EMC_OFS_BASE1 16'hffec
`define EMC_OFS_ROFS 16'hffe9
`define EMC_OFS_WOFS 16'hffe6
`define EMC_OFS_RDAT 16'hffea
`define EMC_OFS_WDAT 16'hffee
`define EMC_CSR_RESET 24'h7c0000
`define EMC_B_EAM 0
`define EMC_B_BW 4
`define EMC_B_WL 5
`define EMC_B_WRAPEN 8
`define EMC_B_INW 9
`define EMC_B_INR 10
`define EMC_B_IS0 11
`define EMC_B_IS1 12
`define EMC_B_RTS 13
`define EMC_B_DTM 14
`define EMC_B_STM 15
`define EMC_B_EN 19
`define EMC_B_BSY 20
`define EMC_B_BDF 21
`define EMC_B_DRF 22
`define EMC_B_DWE 23
`define EMC_CTL_MASK 24'h0fffff
`define EMC_DRAM_SLOW 8'h0c
`define EMC_DRAM_FAST 8'h08
`define EMC_SRAM_BASE 8'h04
`endif

// ### hw/emc_pkg.sv
package emc_pkg;
  typedef enum logic [2:0] {
    EMC_WL_8 = 3'h0, EMC_WL_16 = 3'h1, EMC_WL_24 = 3'h2, EMC_WL_16A24 = 3'h3,
    EMC_WL_RSV4 = 3'h4, EMC_WL_12 = 3'h5, EMC_WL_20 = 3'h6, EMC_WL_RSV7 = 3'h7
  } emc_wl_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [23:0] wdata;
    logic wr;
    logic rd;
  } emc_bus_t;
  typedef struct packed {
    logic start;
    logic is_read;
    logic [23:0] addr;
    logic [23:0] wdata;
  } emc_req_t;
endpackage : emc_pkg

// ### hw/emc_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "emc_regs.svh"
// Counts the cycles of one word transfer and reports completion
module emc_timer
  import emc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sreset,
  // Control
  input wire logic start,
  input wire logic [7:0] cycles,
  // Status
  output logic running,
  output logic done
);
  logic [7:0] cnt_q, cnt_d;
  logic run_q, run_d;

  // Load on start, count down; done marks the last counted cycle
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    if (sreset) begin
      run_d = 1'b0;
      cnt_d = 8'h00;
    end else if (start && !run_q) begin
      run_d = 1'b1;
      cnt_d = cycles - 8'h01;
    end else if (run_q) begin
      if (cnt_q == 8'h00) begin
        run_d = 1'b0;
      end else begin
        cnt_d = cnt_q - 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

  // Done stands while the strobe is still up, so read data is taken before release
  assign running = run_q;
  assign done = run_q && (cnt_q == 8'h00);
endmodule : emc_timer
`default_nettype wire

// ### hw/emc_cycles.sv
`timescale 1ns/10ps
`default_nettype none
`include "emc_regs.svh"
// Works out the clock cycles of one word from width, mode and timing
module emc_cycles
  import emc_pkg::*;
(
  // Configuration
  input wire logic [3:0] mode,
  input wire logic bus8,
  input wire logic [2:0] wlen,
  input wire logic dram_slow,
  input wire logic [3:0] sram_wait,
  // Result
  output logic [7:0] cycles
);
  // Accesses per word: bits carried divided by bus width, rounded up
  function automatic logic [2:0] accesses(input logic [2:0] wl, input logic b8);
    logic [4:0] bits;
    bits = 5'd24;
    case (wl)
      3'h0: bits = 5'd8;
      3'h1, 3'h3: bits = 5'd16;
      3'h5: bits = 5'd12;
      3'h6: bits = 5'd20;
      default: bits = 5'd24;
    endcase
    if (b8) accesses = 3'((bits + 5'd7) >> 3);
    else accesses = 3'((bits + 5'd3) >> 2);
  endfunction : accesses

  logic [2:0] n;
  logic absdram;

  // Absolute DRAM modes are 1100..1111
  always_comb begin
    n = accesses(wlen, bus8);
    absdram = (mode[3:2] == 2'h3);
    if (absdram) begin
      cycles = 8'(n) * (dram_slow ? `EMC_DRAM_SLOW : `EMC_DRAM_FAST);
    end else begin
      cycles = 8'(n) * (`EMC_SRAM_BASE + {4'h0, sram_wait});
    end
  end
endmodule : emc_cycles
`default_nettype wire

// ### hw/emc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "emc_regs.svh"
// External memory interface control and status
module emc_top
  import emc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata,
  // External memory side
  output logic [23:0] mem_addr,
  output logic [23:0] mem_wdata,
  output logic mem_read,
  output logic mem_write,
  input wire logic [23:0] mem_rdata,
  // Interrupt requests to the core
  output logic irq_write,
  output logic irq_read,
  output logic irq_wrap0,
  output logic irq_wrap1
);
  // Control register fields
  logic [23:0] csr_q, csr_d;
  logic [23:0] base0_q, base0_d, base1_q, base1_d;
  logic [23:0] rofs_q, rofs_d, wofs_q, wofs_d;
  // Data path
  logic [23:0] wdat_q, wdat_d, rdat_q, rdat_d, rbuf_q, rbuf_d;
  logic wfull_q, wfull_d, rfull_q, rfull_d, bfull_q, bfull_d;
  logic rpend_q, rpend_d;
  logic [23:0] rdata_q, rdata_d;
  logic wrap0_q, wrap0_d, wrap1_q, wrap1_d;
  // Transfer sequencing
  typedef enum logic [2:0] {
    EMC_IDLE = 3'b001, EMC_RD = 3'b010, EMC_WR = 3'b100
  } emc_st_t;
  emc_st_t st_q, st_d;
  logic [23:0] xaddr_q, xaddr_d;
  logic tmr_start, tmr_run, tmr_done;
  logic [7:0] cyc;
  logic sreset;
  emc_bus_t bus;

  // Register decode helper, used by both strobes
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign sreset = !csr_q[`EMC_B_EN];

  emc_cycles u_cycles (
    .mode(csr_q[`EMC_B_EAM +: 4]),
    .bus8(csr_q[`EMC_B_BW]),
    .wlen(csr_q[`EMC_B_WL +: 3]),
    .dram_slow(csr_q[`EMC_B_DTM]),
    .sram_wait(csr_q[`EMC_B_STM +: 4]),
    .cycles(cyc)
  );

  emc_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .sreset(sreset),
    .start(tmr_start),
    .cycles(cyc),
    .running(tmr_run),
    .done(tmr_done)
  );

  // Registers, data buffers and transfer sequencing
  always_comb begin
    logic wr_csr, rd_trig, rd_data;
    wr_csr = bus.wr && hit(bus.addr, `EMC_OFS_CSR);
    rd_data = bus.rd && hit(bus.addr, `EMC_OFS_RDAT);
    // Read trigger source chosen by the trigger-select bit
    rd_trig = csr_q[`EMC_B_RTS] ? rd_data : (bus.wr && hit(bus.addr, `EMC_OFS_ROFS));
    csr_d = csr_q;
    base0_d = base0_q;
    base1_d = base1_q;
    rofs_d = rofs_q;
    wofs_d = wofs_q;
    wdat_d = wdat_q;
    wfull_d = wfull_q;
    rdat_d = rdat_q;
    rfull_d = rfull_q;
    rbuf_d = rbuf_q;
    bfull_d = bfull_q;
    rpend_d = rpend_q;
    st_d = st_q;
    xaddr_d = xaddr_q;
    tmr_start = 1'b0;
    wrap0_d = 1'b0;
    wrap1_d = 1'b0;
    // Status bits are never writable; only control bits take the write
    if (wr_csr) begin
      csr_d = (csr_q & ~`EMC_CTL_MASK) | (bus.wdata & `EMC_CTL_MASK);
    end
    if (bus.wr && hit(bus.addr, `EMC_OFS_BASE0)) base0_d = bus.wdata;
    if (bus.wr && hit(bus.addr, `EMC_OFS_BASE1)) base1_d = bus.wdata;
    if (bus.wr && hit(bus.addr, `EMC_OFS_WOFS)) wofs_d = bus.wdata;
    if (bus.wr && hit(bus.addr, `EMC_OFS_ROFS)) rofs_d = bus.wdata;
    if (rd_trig) rpend_d = 1'b1;
    // Read data register drains; the buffer refills it
    if (rd_data) begin
      rfull_d = bfull_q;
      rdat_d = rbuf_q;
      bfull_d = 1'b0;
    end
    if (bus.wr && hit(bus.addr, `EMC_OFS_WDAT)) begin
      wdat_d = bus.wdata;
      wfull_d = 1'b1;
    end
    case (st_q)
      EMC_IDLE: begin
        // Reads first while the buffer register has room
        if (rpend_q && !bfull_q) begin
          st_d = EMC_RD;
          xaddr_d = base0_q + rofs_q;
          tmr_start = 1'b1;
          rpend_d = rd_trig;
        end else if (wfull_q) begin
          st_d = EMC_WR;
          xaddr_d = base0_q + wofs_q;
          tmr_start = 1'b1;
        end
      end
      EMC_RD: begin
        if (tmr_done) begin
          st_d = EMC_IDLE;
          if (!rfull_d) begin
            rdat_d = mem_rdata;
            rfull_d = 1'b1;
          end else begin
            rbuf_d = mem_rdata;
            bfull_d = 1'b1;
          end
          if (csr_q[`EMC_B_INR]) begin
            base0_d = base0_q + 24'h000001;
            wrap0_d = (base0_q == 24'hffffff);
          end
        end
      end
      EMC_WR: begin
        if (tmr_done) begin
          st_d = EMC_IDLE;
          wfull_d = bus.wr && hit(bus.addr, `EMC_OFS_WDAT);
          if (csr_q[`EMC_B_INW]) begin
            base0_d = base0_q + 24'h000001;
            wrap0_d = (base0_q == 24'hffffff);
          end
        end
      end
      default: st_d = EMC_IDLE;
    endcase
    // Individual reset clears the data path but keeps control bits
    if (sreset) begin
      st_d = EMC_IDLE;
      wfull_d = 1'b0;
      rfull_d = 1'b0;
      bfull_d = 1'b0;
      rpend_d = 1'b0;
    end
    // Status bits tracked inside the control register image
    csr_d[`EMC_B_DWE] = !wfull_d;
    csr_d[`EMC_B_DRF] = rfull_d;
    csr_d[`EMC_B_BDF] = bfull_d && rfull_d;
    csr_d[`EMC_B_BSY] = (st_d != EMC_IDLE) || rpend_d || wfull_d;
    wrap1_d = 1'b0;
    // Read data returns one cycle after the strobe
    rdata_d = 24'h000000;
    if (bus.rd) begin
      case (1'b1)
        hit(bus.addr, `EMC_OFS_CSR): rdata_d = csr_q;
        hit(bus.addr, `EMC_OFS_BASE0): rdata_d = base0_q;
        hit(bus.addr, `EMC_OFS_BASE1): rdata_d = base1_q;
        hit(bus.addr, `EMC_OFS_ROFS): rdata_d = rofs_q;
        hit(bus.addr, `EMC_OFS_WOFS): rdata_d = wofs_q;
        hit(bus.addr, `EMC_OFS_RDAT): rdata_d = rdat_q;
        default: rdata_d = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      csr_q <= `EMC_CSR_RESET;
      base0_q <= 24'h000000;
      base1_q <= 24'h000000;
      rofs_q <= 24'h000000;
      wofs_q <= 24'h000000;
      wdat_q <= 24'h000000;
      rdat_q <= 24'h000000;
      rbuf_q <= 24'h000000;
      wfull_q <= 1'b0;
      rfull_q <= 1'b0;
      bfull_q <= 1'b0;
      rpend_q <= 1'b0;
      rdata_q <= 24'h000000;
      st_q <= EMC_IDLE;
      xaddr_q <= 24'h000000;
      wrap0_q <= 1'b0;
      wrap1_q <= 1'b0;
    end else begin
      csr_q <= csr_d;
      base0_q <= base0_d;
      base1_q <= base1_d;
      rofs_q <= rofs_d;
      wofs_q <= wofs_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      rbuf_q <= rbuf_d;
      wfull_q <= wfull_d;
      rfull_q <= rfull_d;
      bfull_q <= bfull_d;
      rpend_q <= rpend_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
      xaddr_q <= xaddr_d;
      wrap0_q <= wrap0_d;
      wrap1_q <= wrap1_d;
    end
  end

  // Outputs; the external strobes last the whole timed transfer
  assign reg_rdata = rdata_q;
  assign mem_addr = xaddr_q;
  assign mem_wdata = wdat_q;
  assign mem_read = (st_q == EMC_RD) && tmr_run;
  assign mem_write = (st_q == EMC_WR) && tmr_run;
  // Interrupt select decode
  assign irq_write = !csr_q[`EMC_B_IS1] && csr_q[`EMC_B_IS0] && csr_q[`EMC_B_DWE];
  assign irq_read = csr_q[`EMC_B_IS1] &&
    (csr_q[`EMC_B_IS0] ? csr_q[`EMC_B_BDF] : csr_q[`EMC_B_DRF]);
  assign irq_wrap0 = wrap0_q && csr_q[`EMC_B_WRAPEN];
  assign irq_wrap1 = wrap1_q && csr_q[`EMC_B_WRAPEN];
endmodule : emc_top
`default_nettype wire

// ### bench/emc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "emc_regs.svh"
module emc_monitor
  import emc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [23:0] reg_rdata,
  // Strobes and interrupts
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic irq_write,
  input wire logic irq_read,
  input wire logic irq_wrap0
);
  logic [19:0] ctl_q;
  logic [19:0] ctl_d;
  logic [7:0] run_q;
  logic [7:0] run_d;
  // Shadow control bits; the strobe length counter saves a 36-deep repetition
  always_comb begin
    ctl_d = ctl_q;
    if (reg_wr && reg_addr == `EMC_OFS_CSR) begin
      ctl_d = reg_wdata[19:0];
    end
    run_d = mem_write ? run_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= 20'hc0000;
      run_q <= 8'h00;
    end else begin
      ctl_q <= ctl_d;
      run_q <= run_d;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Offset write that must launch a fetch
  sequence ofs_trig_s;
    reg_wr && reg_addr == `EMC_OFS_ROFS && ctl_q[19] && !ctl_q[13] && !mem_read && !mem_write;
  endsequence
  // Data register read that must launch the next fetch
  sequence dat_trig_s;
    reg_rd && reg_addr == `EMC_OFS_RDAT && ctl_q[19] && ctl_q[13] && !mem_read && !mem_write;
  endsequence
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 24'h000000)
    else $error("read data not cleared");
  ofs_trig_a: assert property (ofs_trig_s |-> ##[1:4] mem_read)
    else $error("offset write did not fetch");
  dat_trig_a: assert property (dat_trig_s |-> ##[1:4] mem_read)
    else $error("data read did not fetch");
  wr_status_a: assert property (
    reg_rd && reg_addr == `EMC_OFS_CSR && mem_write |=> !reg_rdata[23] && reg_rdata[20])
    else $error("status wrong during write");
  dram_len_a: assert property (
    $fell(mem_write) && ctl_q[7:0] == 8'h5c |-> run_q == (ctl_q[14] ? 8'h24 : 8'h18))
    else $error("dram word length wrong");
  off_quiet_a: assert property ((!ctl_q[19]) [*3] |-> !mem_read && !mem_write)
    else $error("transfer while disabled");
  irq_off_a: assert property ((ctl_q[12:11] == 2'b00) [*2] |-> !irq_write && !irq_read)
    else $error("interrupt while disabled");
  irq_sel_a: assert property ((ctl_q[12:11] == 2'b01) [*2] |-> !irq_read)
    else $error("read interrupt on write select");
  wrap_gate_a: assert property (!ctl_q[8] |-> !irq_wrap0)
    else $error("wrap interrupt while masked");
endmodule : emc_monitor
bind emc_top emc_monitor emc_monitor_i (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .mem_read, .mem_write, .irq_write, .irq_read, .irq_wrap0);
`default_nettype wire

// ### bench/emc_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module emc_mem_model (
  // Clock
  input wire logic mclk,
  // Transfer side
  input wire logic [23:0] mem_addr,
  input wire logic [23:0] mem_wdata,
  input wire logic mem_read,
  input wire logic mem_write,
  output logic [23:0] mem_rdata
);
  logic [23:0] mem [256];
  logic [23:0] last_q;
  // Small array; only the low address byte decodes
  always @(posedge mclk) begin
    if (mem_write) mem[mem_addr[7:0]] <= mem_wdata;
    if (mem_read) last_q <= mem[mem_addr[7:0]];
  end
  // Released bus shows the inverse of the last word, never a stale copy
  assign mem_rdata = mem_read ? mem[mem_addr[7:0]] : ~last_q;
endmodule : emc_mem_model
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "emc_regs.svh"
module testbench
  import emc_pkg::*;
;
  typedef struct packed {
    logic [15:0] a;
    logic [23:0] d;
    logic [23:0] e;
  } emc_row_t;
  localparam logic [23:0] CFG = 24'h08005c;
  localparam logic [15:0] CSR = `EMC_OFS_CSR;
  localparam logic [15:0] B0 = `EMC_OFS_BASE0;
  localparam emc_row_t ROWS [8] = '{'{B0, 24'h123456, 24'h123456},
    '{`EMC_OFS_BASE1, 24'habcdef, 24'habcdef}, '{`EMC_OFS_WOFS, 24'h7e7e7e, 24'h7e7e7e},
    '{`EMC_OFS_WOFS, 24'h000000, 24'h000000}, '{CSR, 24'h0800bc, 24'h0800bc},
    '{CSR, 24'h0800fc, 24'h0800fc}, '{CSR, CFG, CFG}, '{16'hff00, 24'h5a5a5a, 24'h000000}};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [23:0] reg_wdata = 24'h000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [23:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, v;
  logic mem_read, mem_write, irq_write, irq_read, irq_wrap0, irq_wrap1;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int wraps = 0;
  int wcyc = 0;
  int w0;
  emc_top emc_top_i (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .mem_addr, .mem_wdata, .mem_read, .mem_write, .mem_rdata, .irq_write, .irq_read,
    .irq_wrap0, .irq_wrap1);
  emc_mem_model emc_mem_model_i (.mclk, .mem_addr, .mem_wdata, .mem_read, .mem_write,
    .mem_rdata);
  always #2 mclk = ~mclk;
  // Watchdog plus counts of wrap pulses and write strobe cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (irq_wrap0 === 1'b1) wraps <= wraps + 1;
    if (mem_write === 1'b1) wcyc <= wcyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic ck(input string n, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : ck
  task automatic ckb(input string n, input logic e, input logic g);
    ck(n, {23'h0, e}, {23'h0, g});
  endtask : ckb
  task automatic wr(input logic [15:0] a, input logic [23:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [23:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Poll busy with a bound; leaves the final status in v
  task automatic idle();
    v = 24'hffffff;
    for (int i = 0; i < 100 && v[20]; i++) rd(CSR, v);
    ckb("busy", 1'b0, v[20]);
  endtask : idle
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rd(CSR, v);
    ck("csr reset", 24'h0c0000, v & `EMC_CTL_MASK);
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, v);
      ck("row", ROWS[i].e, v & (ROWS[i].a == CSR ? `EMC_CTL_MASK : 24'hffffff));
    end
    // Slow then fast DRAM writes; config only changes while idle
    for (int t = 0; t < 2; t++) begin
      wr(CSR, CFG | (t ? 24'h000000 : 24'h004200));
      wr(B0, 24'h000100);
      w0 = wcyc;
      wr(`EMC_OFS_WDAT, 24'ha5a500 + 24'(t));
      rd(CSR, v);
      ckb("empty", 1'b0, v[23]);
      ckb("busy", 1'b1, v[20]);
      idle();
      ckb("empty", 1'b1, v[23]);
      ck("cycles", t ? 24'h18 : 24'h24, 24'(wcyc - w0));
      rd(B0, v);
      ck("base", 24'h000101 - 24'(t), v);
    end
    // Offset triggered reads with and without base advance
    for (int t = 0; t < 2; t++) begin
      wr(CSR, CFG | (t ? 24'h000400 : 24'h000000));
      wr(B0, 24'h000100);
      wr(`EMC_OFS_ROFS, 24'h000000);
      idle();
      ckb("full", 1'b1, v[22]);
      rd(`EMC_OFS_RDAT, v);
      ck("data", 24'ha5a501, v);
      rd(B0, v);
      ck("base", 24'h000100 + 24'(t), v);
    end
    wr(CSR, CFG);
    wr(B0, 24'h000100);
    wr(`EMC_OFS_ROFS, 24'h000000);
    idle();
    wr(`EMC_OFS_ROFS, 24'h000000);
    idle();
    ckb("buffer", 1'b1, v[21]);
    // Every select code with both read words held and the write side empty
    for (int s = 0; s < 4; s++) begin
      wr(CSR, CFG | (24'(s) << 11));
      @(posedge mclk);
      #1;
      ckb("irq_write", s == 1, irq_write);
      ckb("irq_read", s > 1, irq_read);
    end
    rd(`EMC_OFS_RDAT, v);
    rd(CSR, v);
    ckb("buffer", 1'b0, v[21]);
    wr(CSR, CFG | 24'h002000);
    rd(`EMC_OFS_RDAT, v);
    rd(CSR, v);
    ckb("busy", 1'b1, v[20]);
    idle();
    ckb("full", 1'b1, v[22]);
    wr(CSR, CFG);
    rd(`EMC_OFS_RDAT, v);
    rd(CSR, v);
    ckb("full", 1'b0, v[22]);
    // Base rollover, wrap interrupt enabled then masked
    for (int t = 0; t < 2; t++) begin
      wr(CSR, CFG | (t ? 24'h000200 : 24'h000300));
      wr(B0, 24'hffffff);
      wr(`EMC_OFS_WDAT, 24'h00c3c3);
      idle();
      ck("wraps", 24'h000001, 24'(wraps));
      ckb("irq_wrap1", 1'b0, irq_wrap1);
    end
    wr(CSR, 24'h00005c);
    w0 = wcyc;
    wr(`EMC_OFS_WDAT, 24'h000777);
    repeat (40) @(posedge mclk);
    ck("held", 24'(w0), 24'(wcyc));
    stop_test();
  end
endmodule : testbench
`default_nettype wire
